// file: core/ref_select_holdover_map.svh
/*
  register offsets, field positions and reset values for
  the reference selection / holdover control block.
  assumes byte-wide registers on a plain strobe port, 16-bit address.
*/
`ifndef REF_SELECT_HOLDOVER_MAP_SVH
`define REF_SELECT_HOLDOVER_MAP_SVH

// ----------------------------------------------------------------------
// offsets
// ----------------------------------------------------------------------
`define OFS_PHASE_OFFSET_LOW 16'h01ac
`define OFS_PHASE_OFFSET_HIGH 16'h01ad
`define OFS_AUTOMATIC_CONTROL 16'h01c0
`define OFS_MANUAL_OVERRIDE 16'h01c1
`define OFS_AVERAGING_WINDOW 16'h01c2
`define OFS_CONTROL_STATUS 16'h01c4

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define BIT_AUTO_HOLDOVER 0
`define BIT_AUTO_RECOVER 1
`define BIT_AUTO_SELECT 2
`define BIT_HOLDOVER_SOURCE 4
`define BIT_HOLDOVER_SWITCH 0
`define BIT_HOLDOVER_OVERRIDE 1
`define BIT_INPUT_PICK 2
`define BIT_REF_OVERRIDE 3
`define BIT_LINE_CARD 4

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define RST_BYTE 8'h00
`define RST_AVG_SIZE 4'h0

`endif

// file: core/ref_select_holdover_pkg.sv
/*
  types for the reference selection / holdover control block.
  assumes the map header is compiled alongside.
*/
package ref_select_holdover_pkg;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_type;

  typedef struct packed {
    logic refALost;
    logic refBLost;
    logic refAValid;
    logic refBValid;
  } ref_health_type;

  typedef enum logic [1:0] {
    TRACK,
    HOLDOVER,
    SWITCHING
  } ref_state_type;

endpackage : ref_select_holdover_pkg

// file: core/ref_select_holdover_ctrl.sv
/*
  reference selection, holdover and phase offset control.
  assumes synchronous inputs on clk, reference health from a monitor,
  a tuning word from the loop filter and a loop-clock tick from outside.
*/
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
`include "ref_select_holdover_map.svh"

module ref_select_holdover_ctrl #(
  parameter int TW_WIDTH = 48,
  parameter int MAX_AVG_EXP = 15,
  parameter int SWITCH_GAP = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire ref_select_holdover_pkg::reg_req_type busReq,
  output logic [7:0] rdata,
  input wire ref_select_holdover_pkg::ref_health_type refHealth,
  input wire logic refChoicePin,
  input wire logic holdoverPin,
  input wire logic loopClosed,
  input wire logic loopTick,
  input wire logic [TW_WIDTH-1:0] loopTuningWord,
  input wire logic [TW_WIDTH-1:0] frequencyTuningWord,
  output logic [15:0] phaseOffsetWord,
  output logic [TW_WIDTH-1:0] synthTuningWord,
  output logic activeRef,
  output logic refMuxGate,
  output logic inHoldover
);
  import ref_select_holdover_pkg::*;

  // --------------------------------------------------------------------
  // register file
  // --------------------------------------------------------------------
  logic [7:0] phaseLow_reg;
  logic [7:0] phaseHigh_reg;
  logic [7:0] autoCtrl_reg;
  logic [7:0] override_reg;
  logic [3:0] avgSize_reg;
  logic [7:0] rdata_reg;

  wire selPhLow = busReq.addr == `OFS_PHASE_OFFSET_LOW;
  wire selPhHigh = busReq.addr == `OFS_PHASE_OFFSET_HIGH;
  wire selAuto = busReq.addr == `OFS_AUTOMATIC_CONTROL;
  wire selOvr = busReq.addr == `OFS_MANUAL_OVERRIDE;
  wire selAvg = busReq.addr == `OFS_AVERAGING_WINDOW;
  wire selStat = busReq.addr == `OFS_CONTROL_STATUS;

  wire autoHoldEn = autoCtrl_reg[`BIT_AUTO_HOLDOVER];
  wire autoRecEn = autoCtrl_reg[`BIT_AUTO_RECOVER];
  wire autoSelEn = autoCtrl_reg[`BIT_AUTO_SELECT];
  wire holdAvg = autoCtrl_reg[`BIT_HOLDOVER_SOURCE];
  wire holdSwitch = override_reg[`BIT_HOLDOVER_SWITCH];
  wire holdOvr = override_reg[`BIT_HOLDOVER_OVERRIDE];
  wire pickBit = override_reg[`BIT_INPUT_PICK];
  wire refOvr = override_reg[`BIT_REF_OVERRIDE];
  wire lineCard = override_reg[`BIT_LINE_CARD];

  ref_state_type state_reg;
  ref_state_type state_next;
  logic activeRef_reg;
  logic targetRef_reg;

  // unmapped addresses and reserved bits read zero
  wire [7:0] readMux =
    selPhLow ? phaseLow_reg :
    selPhHigh ? phaseHigh_reg :
    selAuto ? {3'h0, autoCtrl_reg[4], 1'h0, autoCtrl_reg[2:0]} :
    selOvr ? {3'h0, override_reg[4:0]} :
    selAvg ? {4'h0, avgSize_reg} :
    selStat ? {5'h0, state_reg == SWITCHING, activeRef_reg, state_reg == HOLDOVER} :
    8'h00;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phaseLow_reg <= `RST_BYTE;
      phaseHigh_reg <= `RST_BYTE;
      autoCtrl_reg <= `RST_BYTE;
      override_reg <= `RST_BYTE;
      avgSize_reg <= `RST_AVG_SIZE;
    end else if (busReq.wr) begin
      if (selPhLow) phaseLow_reg <= busReq.wdata;
      if (selPhHigh) phaseHigh_reg <= busReq.wdata;
      if (selAuto) autoCtrl_reg <= busReq.wdata;
      if (selOvr) override_reg <= busReq.wdata;
      if (selAvg) avgSize_reg <= busReq.wdata[3:0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= busReq.rd ? readMux : 8'h00;
    end
  end
  assign rdata = rdata_reg;

  // --------------------------------------------------------------------
  // reference and holdover decision
  // --------------------------------------------------------------------
  wire curLost = activeRef_reg ? refHealth.refBLost : refHealth.refALost;
  wire otherValid = activeRef_reg ? refHealth.refAValid : refHealth.refBValid;
  wire curValid = activeRef_reg ? refHealth.refBValid : refHealth.refAValid;
  wire anyValid = refHealth.refAValid | refHealth.refBValid;

  // manual pick wins over the pin; 0 first input, 1 second
  wire wantedRef = refOvr ? pickBit : refChoicePin;
  // auto selector steers away from a lost wanted reference; judged on the
  // wanted input, not the active one, so the choice cannot ping-pong
  wire wantedLost = wantedRef ? refHealth.refBLost : refHealth.refALost;
  wire wantedAltValid = wantedRef ? refHealth.refAValid : refHealth.refBValid;
  wire autoMove = autoSelEn && !refOvr && wantedLost && wantedAltValid;
  wire desiredRef = autoMove ? ~wantedRef : wantedRef;

  // manual holdover switch only counts under override
  wire manualHold = holdSwitch;
  wire pinHold = holdoverPin;
  wire autoEnter = autoHoldEn && curLost && !(autoSelEn && !refOvr && otherValid);
  wire autoLeave = autoRecEn && (curValid || (autoSelEn && !refOvr && anyValid));
  wire enterHold = holdOvr ? manualHold : (pinHold || autoEnter);
  wire leaveHold = holdOvr ? !manualHold : (!pinHold && autoLeave);

  logic [$clog2(SWITCH_GAP+1)-1:0] gapCnt_reg;
  wire gapDone = gapCnt_reg == '0;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      TRACK: begin
        if (enterHold) state_next = HOLDOVER;
        else if (desiredRef != activeRef_reg) state_next = SWITCHING;
      end
      HOLDOVER: begin
        if (leaveHold) state_next = TRACK;
      end
      SWITCHING: begin
        if (gapDone) state_next = TRACK;
      end
      default: state_next = TRACK;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= TRACK;
      activeRef_reg <= 1'b0;
      targetRef_reg <= 1'b0;
      gapCnt_reg <= '0;
    end else begin
      state_reg <= state_next;
      if (state_reg == TRACK && state_next == SWITCHING) begin
        targetRef_reg <= desiredRef;
        // line card: gate the mux for a quiet gap so no runt escapes
        gapCnt_reg <= lineCard ? ($clog2(SWITCH_GAP+1))'(SWITCH_GAP) : '0;
      end else if (!gapDone) begin
        gapCnt_reg <= gapCnt_reg - 1'b1;
      end
      if (state_reg == SWITCHING && gapDone) activeRef_reg <= targetRef_reg;
      // leaving holdover may also pick up the wanted reference
      if (state_reg == HOLDOVER && leaveHold) activeRef_reg <= desiredRef;
    end
  end

  // --------------------------------------------------------------------
  // tuning word averaging
  // --------------------------------------------------------------------
  // accumulator wide enough for the largest window; trades area for range
  localparam int ACC_W = TW_WIDTH + MAX_AVG_EXP;
  logic [ACC_W-1:0] acc_reg;
  logic [15:0] sampleCnt_reg;
  logic [TW_WIDTH-1:0] avgWord_reg;
  logic [TW_WIDTH-1:0] lastWord_reg;
  logic [TW_WIDTH-1:0] heldWord_reg;

  wire [15:0] windowLen = 16'h0001 << avgSize_reg;
  // compare with >= so shrinking the window mid-count cannot strand the counter
  wire windowEnd = sampleCnt_reg >= windowLen - 16'h0001;
  wire [ACC_W-1:0] accSum = acc_reg + ACC_W'(loopTuningWord);
  wire [ACC_W-1:0] accShift = accSum >> avgSize_reg;
  wire tracking = state_reg != HOLDOVER;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      acc_reg <= '0;
      sampleCnt_reg <= 16'h0000;
      avgWord_reg <= '0;
      lastWord_reg <= '0;
    end else if (loopTick && tracking) begin
      lastWord_reg <= loopTuningWord;
      if (windowEnd) begin
        avgWord_reg <= accShift[TW_WIDTH-1:0];
        acc_reg <= '0;
        sampleCnt_reg <= 16'h0000;
      end else begin
        acc_reg <= accSum;
        sampleCnt_reg <= sampleCnt_reg + 16'h0001;
      end
    end
  end

  // --------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------
  logic [15:0] pow_reg;
  logic [TW_WIDTH-1:0] synth_reg;
  logic muxGate_reg;
  logic hold_reg;
  logic activeOut_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      heldWord_reg <= '0;
      pow_reg <= 16'h0000;
      synth_reg <= '0;
      muxGate_reg <= 1'b0;
      hold_reg <= 1'b0;
      activeOut_reg <= 1'b0;
    end else begin
      if (state_reg != HOLDOVER && state_next == HOLDOVER) begin
        heldWord_reg <= holdAvg ? avgWord_reg : lastWord_reg;
      end
      // closed loop ignores the offset; a glitch at 45 degree steps is inherent
      pow_reg <= loopClosed ? 16'h0000 : {phaseHigh_reg, phaseLow_reg};
      if (state_reg == HOLDOVER) synth_reg <= heldWord_reg;
      else if (loopClosed) synth_reg <= loopTuningWord;
      else synth_reg <= frequencyTuningWord;
      muxGate_reg <= state_reg == SWITCHING && !gapDone;
      hold_reg <= state_reg == HOLDOVER;
      activeOut_reg <= activeRef_reg;
    end
  end

  assign phaseOffsetWord = pow_reg;
  assign synthTuningWord = synth_reg;
  assign refMuxGate = muxGate_reg;
  assign inHoldover = hold_reg;
  assign activeRef = activeOut_reg;

endmodule : ref_select_holdover_ctrl

// file: verification/ref_select_holdover_assertions.sv
/* checker for reference select / holdover control ports.
   assumes bind onto the control module; override changes only by bus writes. */
`timescale 1ns/1ps
`include "ref_select_holdover_map.svh"
module ref_select_holdover_assertions #(
  parameter int TW_WIDTH = 48
) (
  input wire logic clk,
  input wire logic rst,
  input wire ref_select_holdover_pkg::reg_req_type busReq,
  input wire logic [7:0] rdata,
  input wire logic loopClosed,
  input wire logic [TW_WIDTH-1:0] frequencyTuningWord,
  input wire logic [15:0] phaseOffsetWord,
  input wire logic [TW_WIDTH-1:0] synthTuningWord,
  input wire logic activeRef,
  input wire logic refMuxGate,
  input wire logic inHoldover
);
  import ref_select_holdover_pkg::*;
  // ----------------------------------------
  // override shadow, age saturates so checks wait out switching
  // ----------------------------------------
  logic [7:0] ovrReg;
  logic [3:0] ageReg;
  wire ovrWrite = busReq.wr && busReq.addr == `OFS_MANUAL_OVERRIDE;
  wire settled = ageReg == 4'hf;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ovrReg <= 8'h00;
      ageReg <= 4'h0;
    end else begin
      ovrReg <= ovrWrite ? {3'h0, busReq.wdata[4:0]} : ovrReg;
      ageReg <= ovrWrite ? 4'h0 : ageReg + {3'h0, !settled};
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  AST_OVR_READ: assert property (
    busReq.rd && busReq.addr == `OFS_MANUAL_OVERRIDE |=> rdata == ovrReg)
    else $error("override readback wrong");
  AST_PHASE_CLOSED: assert property (
    loopClosed && $past(loopClosed) |-> phaseOffsetWord == 16'h0000)
    else $error("phase word applied with loop closed");
  AST_PHASE_HOLD: assert property (
    !$past(loopClosed) && !$past(loopClosed, 2) && !$past(busReq.wr) && !$past(busReq.wr, 2)
    |-> $stable(phaseOffsetWord)) else $error("phase word moved without write");
  AST_OPEN_WORD: assert property (
    !$past(rst) && !$past(loopClosed) && !$past(loopClosed, 2) && !inHoldover && !$past(inHoldover)
    && $stable(frequencyTuningWord) |-> synthTuningWord == frequencyTuningWord)
    else $error("open loop word not applied");
  AST_PICK: assert property (settled && ovrReg[3] |-> activeRef == ovrReg[2])
    else $error("active reference differs from pick bit");
  AST_PIN_IGNORED: assert property (settled && ovrReg[3] |=> $stable(activeRef))
    else $error("reference moved under override");
  AST_HOLD_FORCE: assert property (
    settled && ovrReg[1] |-> inHoldover == ovrReg[0]) else $error("holdover not forced");
  AST_HOLD_PIN: assert property (settled && ovrReg[1] |=> $stable(inHoldover))
    else $error("holdover moved under override");
  AST_GATE_LEN: assert property ($rose(refMuxGate) |-> refMuxGate[*4])
    else $error("mux gate too short");
  AST_NO_GATE: assert property (settled && !ovrReg[4] |-> !refMuxGate)
    else $error("mux gated without line card mode");
  cover property ($rose(refMuxGate));
  cover property ($rose(inHoldover));
  cover property ($changed(activeRef));
endmodule : ref_select_holdover_assertions
bind ref_select_holdover_ctrl ref_select_holdover_assertions #(.TW_WIDTH(TW_WIDTH)) sva (
  .clk(clk), .rst(rst), .busReq(busReq), .rdata(rdata), .loopClosed(loopClosed),
  .frequencyTuningWord(frequencyTuningWord), .phaseOffsetWord(phaseOffsetWord),
  .synthTuningWord(synthTuningWord), .activeRef(activeRef), .refMuxGate(refMuxGate),
  .inHoldover(inHoldover));

// file: verification/ref_select_holdover_ctrl_tb.sv
/* self-checking bench for reference select / holdover control.
   assumes package, map header and checker are compiled first. */
`timescale 1ns/1ps
`include "ref_select_holdover_map.svh"
module ref_select_holdover_ctrl_tb;
  import ref_select_holdover_pkg::*;
  logic clk, rst, refChoicePin, holdoverPin, loopClosed, loopTick, gateSeen;
  reg_req_type busReq;
  ref_health_type refHealth;
  logic [47:0] loopTuningWord, frequencyTuningWord, synthTuningWord;
  logic [15:0] phaseOffsetWord;
  logic [7:0] rdata;
  logic activeRef, refMuxGate, inHoldover;
  int failures, testsRun, cycles;
  ref_select_holdover_ctrl #(.TW_WIDTH(48), .MAX_AVG_EXP(15), .SWITCH_GAP(4)) dut (
    .clk(clk), .rst(rst), .busReq(busReq), .rdata(rdata), .refHealth(refHealth),
    .refChoicePin(refChoicePin), .holdoverPin(holdoverPin), .loopClosed(loopClosed),
    .loopTick(loopTick), .loopTuningWord(loopTuningWord),
    .frequencyTuningWord(frequencyTuningWord), .phaseOffsetWord(phaseOffsetWord),
    .synthTuningWord(synthTuningWord), .activeRef(activeRef), .refMuxGate(refMuxGate),
    .inHoldover(inHoldover));
  // ----------------------------------------
  // clock, tick, timeout
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    loopTick <= cycles % 4 == 0;
    if (refMuxGate === 1'b1) gateSeen <= 1'b1;
    if (cycles == 3000) begin
      failures = failures + 1;
      finish_test();
    end
  end
  task automatic finish_test;
    if (failures == 0 && testsRun > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finish_test
  task automatic chk(input string name, input logic [47:0] exp, input logic [47:0] seen);
    testsRun = testsRun + 1;
    if (seen !== exp) begin
      failures = failures + 1;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    busReq <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    busReq.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [7:0] exp, input string name);
    @(posedge clk);
    busReq <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk);
    busReq.rd <= 1'b0;
    #1 chk(name, {40'h0, exp}, {40'h0, rdata});
  endtask : rd
  // long enough for line card gating to finish
  task automatic settle;
    repeat (16) @(posedge clk);
    #1;
  endtask : settle
  task automatic bit1(input string name, input logic exp, input logic seen);
    chk(name, {47'h0, exp}, {47'h0, seen});
  endtask : bit1
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    rst = 1'b1;
    busReq = '0;
    refHealth = 4'b0011;
    refChoicePin = 1'b0;
    holdoverPin = 1'b0;
    loopClosed = 1'b0;
    loopTick = 1'b0;
    gateSeen = 1'b0;
    cycles = 0;
    loopTuningWord = 48'h111122223333;
    frequencyTuningWord = 48'h0a0b0c0d0e0f;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd(`OFS_MANUAL_OVERRIDE, 8'h00, "override reset");
    wr(`OFS_PHASE_OFFSET_LOW, 8'h34);
    wr(`OFS_PHASE_OFFSET_HIGH, 8'h12);
    wr(`OFS_AUTOMATIC_CONTROL, 8'hff);
    wr(`OFS_AVERAGING_WINDOW, 8'hff);
    rd(`OFS_PHASE_OFFSET_LOW, 8'h34, "phase low");
    rd(`OFS_PHASE_OFFSET_HIGH, 8'h12, "phase high");
    rd(`OFS_AUTOMATIC_CONTROL, 8'h17, "auto control");
    rd(`OFS_AVERAGING_WINDOW, 8'h0f, "avg window");
    rd(16'h0000, 8'h00, "unmapped");
    wr(`OFS_AUTOMATIC_CONTROL, 8'h00);
    settle;
    chk("phase open", 48'h1234, {32'h0, phaseOffsetWord});
    frequencyTuningWord <= 48'h0a0b0c0d0e10;
    settle;
    chk("synth open", 48'h0a0b0c0d0e10, synthTuningWord);
    loopClosed <= 1'b1;
    settle;
    chk("phase closed", 48'h0, {32'h0, phaseOffsetWord});
    wr(`OFS_MANUAL_OVERRIDE, 8'h03);
    settle;
    bit1("forced holdover", 1'b1, inHoldover);
    loopTuningWord <= 48'h444455556666;
    settle;
    chk("held word", 48'h111122223333, synthTuningWord);
    holdoverPin <= 1'b1;
    wr(`OFS_MANUAL_OVERRIDE, 8'h02);
    settle;
    bit1("forced track", 1'b0, inHoldover);
    chk("closed word", 48'h444455556666, synthTuningWord);
    wr(`OFS_AUTOMATIC_CONTROL, 8'h10);
    wr(`OFS_AVERAGING_WINDOW, 8'h01);
    settle;
    wr(`OFS_MANUAL_OVERRIDE, 8'h03);
    settle;
    chk("held average", 48'h444455556666, synthTuningWord);
    wr(`OFS_MANUAL_OVERRIDE, 8'h02);
    settle;
    holdoverPin <= 1'b0;
    wr(`OFS_MANUAL_OVERRIDE, 8'h01);
    settle;
    bit1("switch alone", 1'b0, inHoldover);
    wr(`OFS_MANUAL_OVERRIDE, 8'h0c);
    settle;
    bit1("pick one", 1'b1, activeRef);
    refChoicePin <= 1'b1;
    wr(`OFS_MANUAL_OVERRIDE, 8'h08);
    settle;
    bit1("pick zero", 1'b0, activeRef);
    gateSeen <= 1'b0;
    wr(`OFS_MANUAL_OVERRIDE, 8'h1c);
    settle;
    bit1("mux gated", 1'b1, gateSeen);
    bit1("line card ref", 1'b1, activeRef);
    refChoicePin <= 1'b0;
    wr(`OFS_MANUAL_OVERRIDE, 8'h00);
    settle;
    bit1("pin ref", 1'b0, activeRef);
    wr(`OFS_AUTOMATIC_CONTROL, 8'h04);
    refHealth <= 4'b1001;
    settle;
    bit1("auto switch", 1'b1, activeRef);
    wr(`OFS_AUTOMATIC_CONTROL, 8'h01);
    refHealth <= 4'b1100;
    settle;
    bit1("auto holdover", 1'b1, inHoldover);
    finish_test();
  end
endmodule : ref_select_holdover_ctrl_tb
